// >>> core/acs_core.sv
// converter control: reference choice, result formatting, pacing, config and flag registers.
// assumes register requests arrive as single-cycle strobes from the host link decoder,
// and that the analog converter answers each start pulse with one done pulse.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - reference picked from channel select and input configuration, no separate control
// - ratiometric mode uses sensor supply pins as reference, full scale 1023
// - absolute mode uses internal reference; supply channel additionally divided by eight
// - driver current channels give unsigned code against sense-ratio reference current
// - config register at 0x11, bits 7:6 read zero, resets to zero
// - config bit 5 one selects right justification, zero left
// - config bit 4 one gives signed -512..+511 for ratiometric results, zero unsigned 0..1023
// - config bit 3 holds next sample until result read, else overwrite
// - config writes ignored while a conversion runs
// - flag register at 0x0D: bit1 compare count, bit0 done, write one clears
// - done flag set when result ready, clear when none pending or read
// - compare-count flag set when counter equals programmed target
// - comparator enabled masks done flag from the interrupt output
// - sample rate is maximum rate divided by three-bit divisor
// - codes 000..110 give periods 4 us doubling to 256 us
// - result interval is sample plus conversion plus idle; temperature paced by idle
// - every start inserts a 10 us input settling period
// - single start clears on completion; continuous keeps running and wins
// - input mode bit set means absolute, clear means ratiometric
// - reading result registers clears the done flag
// - temperature conversions limited to one eighth maximum rate for codes 000..011
module acs_core
   import acs_pkg::*;
#(
   parameter int SETTLE_LEN = SETTLE_CYCLES,      // settling cycles after a start
   parameter int BASE_LEN   = BASE_PERIOD_CYCLES  // cycles of the fastest period
) (
   input  wire logic                 clk_in,                 // core clock, 100 MHz
   input  wire logic                 reset_in,               // synchronous reset, active high
   input  wire acs_pkg::acs_reg_req_t reg_req_in,            // register strobe, address, data
   output logic [7:0]                reg_rdata_out,          // read data, valid with read strobe
   input  wire logic [4:0]           input_channel_select_in, // selected measurement channel
   input  wire logic [7:0]           analog_input_config_in, // per-input mode and temp enables
   input  wire logic                 single_convert_start_in, // single conversion request level
   input  wire logic                 continuous_convert_start_in, // continuous request level
   input  wire logic                 comparator_enable_in,   // result comparator enabled
   input  wire logic [7:0]           compare_count_in,       // comparator counter value
   input  wire logic [7:0]           compare_count_target_in, // programmed count target
   input  wire logic                 compare_update_in,      // counter updated this cycle
   input  wire logic                 sar_done_in,            // analog conversion finished
   input  wire logic [9:0]           sar_code_in,            // raw unsigned code, valid with done
   output acs_pkg::acs_ref_t         reference_select_out,   // reference routed to converter
   output logic                      supply_divide_out,      // supply prescaler by eight engaged
   output logic                      signed_result_out,      // result uses signed format
   output logic                      settle_out,             // input stage settling
   output logic                      sample_start_out,       // pulse: start a sample
   output logic                      single_start_clear_out, // pulse: clear single start bit
   output logic                      busy_out,               // a conversion sequence runs
   output logic                      interrupt_out,          // global converter interrupt
   output logic [7:0]                result_high_out,        // formatted result, high byte
   output logic [7:0]                result_low_out          // formatted result, low byte
);
   import acs_pkg::*;

   // ****************************************************************
   // parameter checks
   // ****************************************************************
   initial begin
      if (SETTLE_LEN < 1 || BASE_LEN < 1 || BASE_LEN * 128 >= (1 << 24)) begin
         $error("acs_core: timing parameters out of range");
      end
   end

   // ****************************************************************
   // state and storage
   // ****************************************************************
   typedef enum logic [2:0] {
      ACS_IDLE    = 3'b000,
      ACS_SETTLE  = 3'b001,
      ACS_CONVERT = 3'b010,
      ACS_PACE    = 3'b011,
      ACS_FINISH  = 3'b100
   } acs_state_t;

   acs_state_t   state;
   acs_state_t   next_state;
   logic [7:0]   config_reg;
   logic [1:0]   flag_reg;
   logic [23:0]  timer;
   logic [23:0]  period_len;
   logic [2:0]   rate_code;
   acs_result_t  result;
   logic [7:0]   shadow_byte;
   logic         shadow_valid;
   acs_ref_t     ref_now;
   logic         is_ratio;
   logic         run_req;
   logic         cfg_wr;
   logic         flag_wr;
   logic         rd_high;
   logic         rd_low;
   logic         result_read;
   logic [9:0]   code_fmt;
   logic         just_right;
   logic         sign_en;

   // ****************************************************************
   // reference decode
   // ****************************************************************
   // channel to reference; also used to pick result signedness and rate limit
   function automatic acs_ref_t ref_of(input logic [4:0] ch, input logic [7:0] ain);
      acs_ref_t r;
      r = ACS_REF_VOLTAGE;
      if (ch <= CH_AIN_LAST) begin
         if (ch >= AIN_FIRST_TEMP && ain[AIN_TEMP_EN_LSB + ch[0]]) begin
            r = ACS_REF_TEMP;
         end else if (ain[ch[1:0]]) begin
            r = ACS_REF_VOLTAGE;
         end else begin
            r = ACS_REF_RATIO;
         end
      end else if (ch <= CH_CURRENT_LAST || ch == CH_DIAG_CURRENT) begin
         r = ACS_REF_CURRENT;
      end else if (ch == CH_DIAG_RATIO_A || ch == CH_DIAG_RATIO_B) begin
         r = ACS_REF_RATIO;
      end
      return r;
   endfunction

   // reference follows the live channel and input setup
   always_comb begin
      ref_now  = ref_of(input_channel_select_in, analog_input_config_in);
      is_ratio = (ref_now == ACS_REF_RATIO);
   end

   assign reference_select_out = ref_now;
   assign supply_divide_out    = (input_channel_select_in == CH_SUPPLY);
   assign just_right           = config_reg[CFG_JUSTIFY_BIT];
   // signed form only applies to ratiometric results; current codes stay unsigned
   assign sign_en              = config_reg[CFG_SIGNED_BIT] && is_ratio;
   assign signed_result_out    = sign_en;

   // ****************************************************************
   // register access decode
   // ****************************************************************
   assign run_req     = single_convert_start_in || continuous_convert_start_in;
   assign busy_out    = (state != ACS_IDLE);
   assign cfg_wr      = reg_req_in.wr && reg_req_in.addr == ACS_ADDR_CONFIG && !busy_out;
   assign flag_wr     = reg_req_in.wr && reg_req_in.addr == ACS_ADDR_FLAG;
   assign rd_high     = reg_req_in.rd && reg_req_in.addr == ACS_ADDR_RESULT_HI;
   assign rd_low      = reg_req_in.rd && reg_req_in.addr == ACS_ADDR_RESULT_LO;
   // the byte read first depends on justification; it frees the pair
   assign result_read = just_right ? rd_low : rd_high;

   // configuration register, frozen while converting
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         config_reg <= CFG_RESET;
      end else if (cfg_wr) begin
         config_reg <= reg_req_in.wdata & CFG_WRITE_MASK;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      reg_rdata_out = 8'h00;
      unique case (reg_req_in.addr)
         ACS_ADDR_CONFIG:    reg_rdata_out = config_reg & CFG_WRITE_MASK;
         ACS_ADDR_FLAG:      reg_rdata_out = {6'h00, flag_reg};
         ACS_ADDR_RESULT_HI: reg_rdata_out = (just_right && shadow_valid) ? shadow_byte : result.high;
         ACS_ADDR_RESULT_LO: reg_rdata_out = (!just_right && shadow_valid) ? shadow_byte : result.low;
         default:            reg_rdata_out = 8'h00;
      endcase
   end

   // ****************************************************************
   // flags
   // ****************************************************************
   // hardware set wins over a clear arriving in the same cycle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         flag_reg <= FLAG_RESET;
      end else begin
         if (state == ACS_CONVERT && sar_done_in) begin
            flag_reg[FLAG_DONE_BIT] <= 1'b1;
         end else if (result_read || (flag_wr && reg_req_in.wdata[FLAG_DONE_BIT])) begin
            flag_reg[FLAG_DONE_BIT] <= 1'b0;
         end
         if (compare_update_in && compare_count_in == compare_count_target_in) begin
            flag_reg[FLAG_CMP_BIT] <= 1'b1;
         end else if (flag_wr && reg_req_in.wdata[FLAG_CMP_BIT]) begin
            flag_reg[FLAG_CMP_BIT] <= 1'b0;
         end
      end
   end

   // done flag stays visible in the register but is kept off the interrupt while the comparator is enabled
   assign interrupt_out = flag_reg[FLAG_CMP_BIT] ||
                          (flag_reg[FLAG_DONE_BIT] && !comparator_enable_in);

   // ****************************************************************
   // result formatting
   // ****************************************************************
   // offset binary to two's complement: flipping the top bit centres the range
   assign code_fmt = sign_en ? (sar_code_in ^ 10'h200) : sar_code_in;

   // result pair loads on each finished conversion; unread data is overwritten
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         result <= '0;
      end else if (state == ACS_CONVERT && sar_done_in) begin
         if (just_right) begin
            result.low  <= code_fmt[7:0];
            result.high <= {{6{sign_en & code_fmt[9]}}, code_fmt[9:8]};
         end else begin
            result.high <= code_fmt[9:2];
            result.low  <= {code_fmt[1:0], 6'h00};
         end
      end
   end

   // second byte is frozen when the first is read so a new result cannot tear the pair
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         shadow_byte  <= 8'h00;
         shadow_valid <= 1'b0;
      end else if (result_read) begin
         shadow_byte  <= just_right ? result.high : result.low;
         shadow_valid <= 1'b1;
      end else if ((just_right && rd_high) || (!just_right && rd_low)) begin
         shadow_valid <= 1'b0;
      end
   end

   assign result_high_out = result.high;
   assign result_low_out  = result.low;

   // ****************************************************************
   // sample-rate pacing
   // ****************************************************************
   // external temperature cannot run faster than the eighth-rate code
   always_comb begin
      rate_code = config_reg[CFG_RATE_MSB:0];
      if (ref_now == ACS_REF_TEMP && rate_code < RATE_TEMP_MIN) begin
         rate_code = RATE_TEMP_MIN;
      end
      // period doubles per code, 111 giving 128 times the base
      period_len = 24'(BASE_LEN) << rate_code;
   end

   // ****************************************************************
   // conversion sequencer
   // ****************************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         ACS_IDLE: begin
            if (run_req) begin
               next_state = ACS_SETTLE;
            end
         end
         ACS_SETTLE: begin
            if (!run_req) begin
               next_state = ACS_IDLE;
            end else if (timer == 24'(SETTLE_LEN - 1)) begin
               next_state = ACS_CONVERT;
            end
         end
         ACS_CONVERT: begin
            if (sar_done_in) begin
               // continuous wins when both are requested
               next_state = continuous_convert_start_in ? ACS_PACE : ACS_FINISH;
            end
         end
         ACS_PACE: begin
            // sample, conversion and idle all fit inside one period
            if (!continuous_convert_start_in) begin
               next_state = ACS_IDLE;
            end else if (timer >= period_len - 24'd1 &&
                         !(config_reg[CFG_HOLD_BIT] && flag_reg[FLAG_DONE_BIT])) begin
               next_state = ACS_CONVERT;
            end
         end
         ACS_FINISH: begin
            next_state = ACS_IDLE;
         end
         default: begin
            next_state = ACS_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= ACS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // timer counts settle cycles, then cycles since the current sample started
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         timer <= 24'd0;
      end else if (state != next_state && next_state != ACS_PACE) begin
         timer <= 24'd0;
      end else if (timer != 24'hFF_FFFF) begin
         timer <= timer + 24'd1;
      end
   end

   // start pulse on entering convert; single start cleared once its result is stored
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sample_start_out       <= 1'b0;
         single_start_clear_out <= 1'b0;
      end else begin
         sample_start_out       <= (next_state == ACS_CONVERT && state != ACS_CONVERT);
         single_start_clear_out <= (state == ACS_CONVERT && next_state == ACS_FINISH);
      end
   end

   assign settle_out = (state == ACS_SETTLE);

endmodule

`default_nettype wire

// >>> include/acs_pkg.sv
// package for the converter configuration, status and rate block.
// assumes a 100 MHz core clock and byte-wide register access from the host link.
package acs_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] ACS_ADDR_FLAG       = 8'h0D;
   localparam logic [7:0] ACS_ADDR_CONFIG     = 8'h11;
   localparam logic [7:0] ACS_ADDR_RESULT_HI  = 8'h0E;
   localparam logic [7:0] ACS_ADDR_RESULT_LO  = 8'h0F;

   // configuration register fields
   localparam int CFG_JUSTIFY_BIT  = 5;
   localparam int CFG_SIGNED_BIT   = 4;
   localparam int CFG_HOLD_BIT     = 3;
   localparam int CFG_RATE_MSB     = 2;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;

   // flag register fields
   localparam int FLAG_DONE_BIT    = 0;
   localparam int FLAG_CMP_BIT     = 1;
   localparam logic [1:0] FLAG_RESET = 2'b00;

   // channel select codes
   localparam logic [4:0] CH_AIN_LAST     = 5'h03;
   localparam logic [4:0] CH_CURRENT_LAST = 5'h0F;
   localparam logic [4:0] CH_SUPPLY       = 5'h10;
   localparam logic [4:0] CH_DIAG_RATIO_A = 5'h19;
   localparam logic [4:0] CH_DIAG_RATIO_B = 5'h1A;
   localparam logic [4:0] CH_DIAG_CURRENT = 5'h1F;

   // analog input configuration fields
   localparam int AIN_TEMP_EN_LSB  = 4;
   localparam int AIN_FIRST_TEMP   = 2;

   // rate limit for external temperature conversions
   localparam logic [2:0] RATE_TEMP_MIN = 3'b011;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS    = 10;
   localparam int SETTLE_NS        = 10000;
   localparam int BASE_PERIOD_NS   = 4000;
   localparam int SETTLE_CYCLES    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      ACS_REF_RATIO   = 2'b00,
      ACS_REF_VOLTAGE = 2'b01,
      ACS_REF_CURRENT = 2'b10,
      ACS_REF_TEMP    = 2'b11
   } acs_ref_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acs_reg_req_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } acs_result_t;

endpackage

// >>> verif/acs_core_assertions.sv
// checker for the converter control block, bound to acs_core.
// sees only the block's ports; registers are seen through read data.
`timescale 1ns/100ps
`default_nettype none
module acs_core_assertions
   import acs_pkg::*;
#(
   parameter int SETTLE_LEN = 20, // settling cycles after a start
   parameter int BASE_LEN   = 4   // cycles of the fastest period
) (
   input wire logic                  clk_in,                      // core clock
   input wire logic                  reset_in,                    // sync reset
   input wire acs_pkg::acs_reg_req_t reg_req_in,                  // register request
   input wire logic [7:0]            reg_rdata_out,               // read data
   input wire logic [4:0]            input_channel_select_in,     // channel
   input wire logic [7:0]            analog_input_config_in,      // input config
   input wire logic                  single_convert_start_in,     // single level
   input wire logic                  continuous_convert_start_in, // continuous level
   input wire logic                  comparator_enable_in,        // comparator on
   input wire logic                  sar_done_in,                 // converter done
   input wire acs_pkg::acs_ref_t     reference_select_out,        // reference
   input wire logic                  supply_divide_out,           // supply prescaler
   input wire logic                  settle_out,                  // settling
   input wire logic                  sample_start_out,            // sample pulse
   input wire logic                  single_start_clear_out,      // single clear pulse
   input wire logic                  busy_out,                    // sequence running
   input wire logic                  interrupt_out                // interrupt
);
   // ****************************************************************
   // helpers and properties
   // ****************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic [15:0] settle_cnt;
   // settle length
   always_ff @(posedge clk_in) begin
      if (reset_in || !settle_out) settle_cnt <= 16'h0000;
      else settle_cnt <= settle_cnt + 16'h0001;
   end
   AST_CFG_UNUSED: assert property (reg_req_in.addr == ACS_ADDR_CONFIG |-> reg_rdata_out[7:6] == 2'b00)
      else $error("config top bits not zero");
   AST_FLAG_UNUSED: assert property (reg_req_in.addr == ACS_ADDR_FLAG |-> reg_rdata_out[7:2] == 6'h00)
      else $error("flag top bits not zero");
   AST_IRQ_MASKED: assert property (comparator_enable_in && reg_req_in.addr == ACS_ADDR_FLAG
      |-> interrupt_out == reg_rdata_out[1]) else $error("done flag not masked");
   AST_IRQ_OPEN: assert property (!comparator_enable_in && reg_req_in.addr == ACS_ADDR_FLAG
      |-> interrupt_out == (reg_rdata_out[1] | reg_rdata_out[0])) else $error("interrupt not from flags");
   AST_SETTLE_LEN: assert property ($fell(settle_out) && busy_out |-> settle_cnt >= SETTLE_LEN)
      else $error("settling too short");
   AST_SETTLE_START: assert property ($fell(settle_out) && busy_out |-> ##[0:1] sample_start_out)
      else $error("no sample after settling");
   AST_SINGLE_CLEAR: assert property (sar_done_in && busy_out && single_convert_start_in
      && !continuous_convert_start_in |=> single_start_clear_out) else $error("single start not cleared");
   AST_CFG_LOCK: assert property (busy_out && reg_req_in.wr && reg_req_in.addr == ACS_ADDR_CONFIG
      ##1 reg_req_in.addr == ACS_ADDR_CONFIG |-> $stable(reg_rdata_out)) else $error("config written while busy");
   AST_SUPPLY_DIV: assert property (supply_divide_out == (input_channel_select_in == CH_SUPPLY))
      else $error("supply prescaler wrong");
   AST_REF_CURRENT: assert property (input_channel_select_in inside {[5'h04:5'h0F]}
      |-> reference_select_out == ACS_REF_CURRENT) else $error("current reference wrong");
   AST_REF_MODE: assert property (input_channel_select_in <= 5'h01 |-> reference_select_out ==
      (analog_input_config_in[input_channel_select_in[0]] ? ACS_REF_VOLTAGE : ACS_REF_RATIO))
      else $error("input mode reference wrong");
   COV_SAMPLE: cover property (sample_start_out);
   COV_CLEAR: cover property (single_start_clear_out);
   COV_CMP_IRQ: cover property (interrupt_out && comparator_enable_in);
endmodule

bind acs_core acs_core_assertions #(.SETTLE_LEN(SETTLE_LEN), .BASE_LEN(BASE_LEN)) u_chk (.*);
`default_nettype wire

// >>> verif/acs_sar_model.sv
// stand-in for the analog converter: one done pulse and a code for each sample start.
// assumes the bench supplies the code to report.
`timescale 1ns/100ps
`default_nettype none
module acs_sar_model #(
   parameter int LAT = 6 // conversion cycles
) (
   input  wire logic       clk_in,   // core clock
   input  wire logic       start_in, // sample start pulse
   input  wire logic [9:0] code_in,  // code to report
   output logic            done_out, // done pulse
   output logic [9:0]      code_out  // code, valid with done only
);
   int cnt = 0;
   initial begin
      done_out = 1'b0;
      code_out = 10'h000;
   end
   // code bus shows junk outside the done cycle
   always @(posedge clk_in) begin
      done_out <= (cnt == 1);
      code_out <= (cnt == 1) ? code_in : ~code_out;
      if (start_in) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the converter control block.
// assumes the converter stand-in model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import acs_pkg::*;
   localparam int SL = 20;
   localparam int BL = 4;
   logic         clk_in = 0, reset_in = 1, sgl = 0, cont = 0, cmp_en = 0, cupd = 0;
   logic         sdone, sss, sclr, busy, irq, sdiv, sgn, stl;
   acs_reg_req_t req = '0;
   logic [7:0]   rdata, rhi, rlo, ccnt = 0, ctgt = 0, aic = 0;
   logic [4:0]   ch = 0;
   logic [9:0]   scode, code = 0;
   acs_ref_t     rsel;
   logic [7:0]   exp_q[$];
   logic [31:0]  seed = 32'hfe39;
   int           num_errors = 0, n_tests = 0, cyc = 0, n, k;
   logic [4:0]   chs[8] = '{0, 1, 2, 3, 3, 4, 15, 16};
   logic [7:0]   aics[8] = '{0, 2, 8'h10, 8'h28, 8'h08, 0, 0, 0};
   logic [1:0]   refs[8] = '{0, 1, 3, 3, 1, 2, 2, 1};
   always #5 clk_in = ~clk_in;
   acs_core #(.SETTLE_LEN(SL), .BASE_LEN(BL)) DUT (
      .clk_in(clk_in), .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .input_channel_select_in(ch), .analog_input_config_in(aic), .single_convert_start_in(sgl),
      .continuous_convert_start_in(cont), .comparator_enable_in(cmp_en), .compare_count_in(ccnt),
      .compare_count_target_in(ctgt), .compare_update_in(cupd), .sar_done_in(sdone), .sar_code_in(scode),
      .reference_select_out(rsel), .supply_divide_out(sdiv), .signed_result_out(sgn), .settle_out(stl),
      .sample_start_out(sss), .single_start_clear_out(sclr), .busy_out(busy), .interrupt_out(irq),
      .result_high_out(rhi), .result_low_out(rlo));
   acs_sar_model #(.LAT(1)) u_sar (.clk_in(clk_in), .start_in(sss), .code_in(code), .done_out(sdone),
      .code_out(scode));
   // ****************************************************************
   // tasks
   // ****************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic report(input string nm, input logic [9:0] e, input logic [9:0] g);
      n_tests++;
      if (e !== g) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one-cycle strobes; address is left standing
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      req = '{1'b1, 1'b0, a, d};
      @(negedge clk_in);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_in);
      req = '{1'b0, 1'b1, a, 8'h00};
      exp_q.push_back(e);
      @(negedge clk_in);
      req.rd = 1'b0;
   endtask
   // a single start; poke tries a config write while the sequence runs
   task automatic single_conv(input logic poke);
      seed = xs(seed);
      code = seed[9:0];
      @(negedge clk_in);
      sgl = 1'b1;
      if (poke) wr(ACS_ADDR_CONFIG, 8'h00);
      for (k = 0; k < 400 && sclr !== 1'b1; k++) @(negedge clk_in);
      sgl = 1'b0;
   endtask
   task automatic cpulse(input logic [7:0] c);
      @(negedge clk_in);
      ccnt = c;
      ctgt = 8'h05;
      cupd = 1'b1;
      @(negedge clk_in);
      cupd = 1'b0;
   endtask
   // cycles between two continuous sample starts
   task automatic period(input logic [7:0] cfg, input int e);
      wr(ACS_ADDR_CONFIG, cfg);
      cont = 1'b1;
      for (k = 0; k < 200 && sss !== 1'b1; k++) @(negedge clk_in);
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (sss !== 1'b1 && n < 2000);
      report("period", e[9:0], n[9:0]);
      cont = 1'b0;
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk_in);
   endtask
   // ****************************************************************
   // monitor, watchdog and sequence
   // ****************************************************************
   // every taken read is matched with the oldest expectation
   always @(posedge clk_in) if (req.rd === 1'b1 && exp_q.size() > 0) report("rdata", {2'b00, exp_q.pop_front()}, {2'b00, rdata});
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(posedge clk_in);
      @(negedge clk_in);
      reset_in = 1'b0;
      rd(ACS_ADDR_CONFIG, 8'h00);
      rd(ACS_ADDR_FLAG, 8'h00);
      wr(ACS_ADDR_CONFIG, 8'hFF);
      rd(ACS_ADDR_CONFIG, 8'h3F);
      rd(8'h33, 8'h00);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_in);
         ch = chs[i];
         aic = aics[i];
         @(negedge clk_in);
         report("refsel", {8'h00, refs[i]}, {8'h00, rsel});
         report("supdiv", {9'h000, chs[i] == CH_SUPPLY}, {9'h000, sdiv});
         report("signed", {9'h000, refs[i] == 2'b00}, {9'h000, sgn});
      end
      ch = 5'h00;
      aic = 8'h00;
      single_conv(1'b1);
      rd(ACS_ADDR_CONFIG, 8'h3F);
      rd(ACS_ADDR_FLAG, 8'h01);
      report("irq", 10'h001, {9'h000, irq});
      rd(ACS_ADDR_RESULT_LO, code[7:0]);
      rd(ACS_ADDR_RESULT_HI, {{7{~code[9]}}, code[8]});
      rd(ACS_ADDR_FLAG, 8'h00);
      wr(ACS_ADDR_CONFIG, 8'h00);
      single_conv(1'b0);
      rd(ACS_ADDR_RESULT_HI, code[9:2]);
      rd(ACS_ADDR_FLAG, 8'h00);
      wr(ACS_ADDR_CONFIG, 8'h10);
      single_conv(1'b0);
      rd(ACS_ADDR_RESULT_HI, {~code[9], code[8:2]});
      cmp_en = 1'b1;
      single_conv(1'b0);
      cpulse(8'h04);
      rd(ACS_ADDR_FLAG, 8'h01);
      report("irq", 10'h000, {9'h000, irq});
      cpulse(8'h05);
      rd(ACS_ADDR_FLAG, 8'h03);
      report("irq", 10'h001, {9'h000, irq});
      wr(ACS_ADDR_FLAG, 8'h03);
      rd(ACS_ADDR_FLAG, 8'h00);
      cmp_en = 1'b0;
      for (int r = 0; r < 8; r++) period(8'(r), BL << r);
      ch = 5'h02;
      aic = 8'h10;
      period(8'h00, BL << 3);
      period(8'h04, BL << 4);
      ch = 5'h00;
      aic = 8'h00;
      wr(ACS_ADDR_FLAG, 8'h03);
      wr(ACS_ADDR_CONFIG, 8'h08);
      cont = 1'b1;
      n = 0;
      repeat (100) @(negedge clk_in) n += sss;
      report("held", 10'h001, n[9:0]);
      rd(ACS_ADDR_RESULT_HI, code[9:2]);
      n = 0;
      repeat (40) @(negedge clk_in) n += sss;
      report("resumed", 10'h001, n[9:0]);
      cont = 1'b0;
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk_in);
      end_sim();
   end
endmodule
`default_nettype wire
